// ==== include/spo_cfg.svh ====
`ifndef SPO_CFG_SVH
`define SPO_CFG_SVH

// register byte offsets
`define SPO_OFS_CTRL   8'h00
`define SPO_OFS_FIRST_SETPOINT   8'h04
`define SPO_OFS_SECOND_SETPOINT   8'h08
`define SPO_OFS_PT1    8'h0c
`define SPO_OFS_PT2    8'h10
`define SPO_OFS_COUNT  8'h14
`define SPO_OFS_TOTAL  8'h18
`define SPO_OFS_DISP   8'h1c
`define SPO_OFS_STAT   8'h20
`define SPO_OFS_MASK   8'h24
`define SPO_OFS_OUTS   8'h28

// control field positions
`define SPO_CTRL_MODE_LSB 0
`define SPO_CTRL_MODE_MSB 2
`define SPO_CTRL_DIR_BIT  8

// direction code for downcount
`define SPO_DIR_DOWN 1'h1

// status bit positions
`define SPO_ST_OUT1 0
`define SPO_ST_OUT2 1
`define SPO_ST_AUTO 2
`define SPO_ST_MAN  3
`define SPO_ST_W    4

// reset values
`define SPO_RST_CTRL 32'h0000_0000
`define SPO_RST_SET  32'h0000_0000
`define SPO_RST_PT   32'h0000_0000
`define SPO_RST_MASK 4'h0

// pulse-time base: one tick per millisecond
`define SPO_CLK_NS 25
`define SPO_TB_NS  1000000
`define SPO_TB_CYC (`SPO_TB_NS / `SPO_CLK_NS)

`endif

// ==== include/spo_pkg.sv ====
package spo_pkg;

   // output functions
   typedef enum logic [2:0] {
      SPO_MAN_STOP  = 3'h0,
      SPO_MAN_CONT  = 3'h1,
      SPO_AUTO_BASE = 3'h2,
      SPO_AUTO_WAIT = 3'h3,
      SPO_AUTO_HOLD = 3'h4,
      SPO_AUTO_OVR  = 3'h5,
      SPO_COMPARE   = 3'h6
   } spo_mode_t;

   // counting phase, gray along run -> wait -> stop
   typedef enum logic [1:0] {
      SPO_PH_RUN  = 2'h0,
      SPO_PH_WAIT = 2'h1,
      SPO_PH_STOP = 2'h3
   } spo_phase_t;

endpackage

// ==== src/spo_top.sv ====
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/10ps
`include "spo_cfg.svh"

module spo_top #(
   parameter int CNT_W  = 24,
   parameter int PT_W   = 16,
   parameter int TB_CYC = `SPO_TB_CYC
) (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_arst_n,
   // register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   // field pins
   input  wire logic        i_cnt_pulse,
   input  wire logic        i_man_rst,
   // outputs
   output logic             o_out1,
   output logic             o_out2,
   output logic [31:0]      o_disp,
   output logic             o_irq
);

   // tick check wants two quiet cycles between ticks
   if (CNT_W < 8 || CNT_W > 32 || PT_W < 1 || PT_W > 32 || TB_CYC < 3)
   begin : g_bad
      $error("spo_top: unsupported parameter values");
   end

   // registers
   logic [31:0]             ctrl_r;
   logic [CNT_W-1:0]        first_setpoint_r;
   logic [CNT_W-1:0]        second_setpoint_r;
   logic [PT_W-1:0]         pt1_r;
   logic [PT_W-1:0]         pt2_r;
   logic [`SPO_ST_W-1:0]    stat_r;
   logic [`SPO_ST_W-1:0]    mask_r;
   logic signed [CNT_W-1:0] count_r;
   logic signed [31:0]      total_r;
   logic [PT_W-1:0]         t1_r;
   logic [PT_W-1:0]         t2_r;
   logic                    hold_r;
   spo_pkg::spo_phase_t     phase_r;
   logic [31:0]             tb_r;
   logic                    tick;
   logic [2:0]              cp_s;
   logic [2:0]              mr_s;

   // decoded control
   spo_pkg::spo_mode_t      mode;
   logic                    down;
   logic                    cnt_ev;
   logic                    mr_ev;
   logic                    run_ev;
   logic signed [CNT_W-1:0] cnt_n;
   logic signed [CNT_W-1:0] start_val;
   logic signed [CNT_W-1:0] term_val;
   logic                    hit1;
   logic                    term;
   logic                    auto_ok;
   logic                    is_auto;
   logic                    ar_now;
   logic                    t1_exp;
   logic                    t2_exp;
   logic                    late_rst;
   logic                    cmp1;
   logic                    cmp2;
   logic                    first_setpoint_ev;
   logic                    second_setpoint_ev;
   logic [`SPO_ST_W-1:0]    ev_vec;

   assign mode      = spo_pkg::spo_mode_t'(ctrl_r[`SPO_CTRL_MODE_MSB:`SPO_CTRL_MODE_LSB]);
   assign down      = (ctrl_r[`SPO_CTRL_DIR_BIT] == `SPO_DIR_DOWN);
   assign start_val = down ? $signed(second_setpoint_r) : '0;
   assign term_val  = down ? '0 : $signed(second_setpoint_r);

   // field pins: two flops, third only for the edge
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         cp_s <= 3'h0;
         mr_s <= 3'h0;
      end
      else
      begin
         cp_s <= {cp_s[1:0], i_cnt_pulse};
         mr_s <= {mr_s[1:0], i_man_rst};
      end
   end
   assign cnt_ev = cp_s[1] & ~cp_s[2];
   assign mr_ev  = mr_s[1] & ~mr_s[2];

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         tb_r <= 32'h0;
      else if (tb_r == 32'(TB_CYC - 1))
         tb_r <= 32'h0;
      else
         tb_r <= tb_r + 32'h1;
   end
   assign tick = (tb_r == 32'(TB_CYC - 1));

   assign run_ev  = cnt_ev & ~mr_ev & (phase_r == spo_pkg::SPO_PH_RUN);
   assign cnt_n   = down ? count_r - CNT_W'(1) : count_r + CNT_W'(1);
   assign hit1    = (cnt_n == $signed(first_setpoint_r));
   assign term    = (cnt_n == term_val);
   // zero second pulse time disables auto reset
   assign auto_ok = (pt2_r != '0);
   assign is_auto = (mode == spo_pkg::SPO_AUTO_BASE) || (mode == spo_pkg::SPO_AUTO_WAIT)
                  || (mode == spo_pkg::SPO_AUTO_HOLD) || (mode == spo_pkg::SPO_AUTO_OVR);
   assign ar_now  = run_ev & term & auto_ok
                  & ((mode == spo_pkg::SPO_AUTO_BASE) || (mode == spo_pkg::SPO_AUTO_HOLD));
   assign t1_exp  = tick & (t1_r == PT_W'(1));
   assign t2_exp  = tick & (t2_r == PT_W'(1));
   assign late_rst = t2_exp & auto_ok & ~mr_ev
                   & ((mode == spo_pkg::SPO_AUTO_WAIT) || (mode == spo_pkg::SPO_AUTO_OVR));
   assign cmp1    = down ? (count_r <= $signed(first_setpoint_r)) : (count_r >= $signed(first_setpoint_r));
   assign cmp2    = down ? (count_r <= term_val) : (count_r >= term_val);

   // count, phase and total
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         count_r <= '0;
         total_r <= 32'sh0;
         phase_r <= spo_pkg::SPO_PH_RUN;
      end
      else if (mr_ev || late_rst)
      begin
         total_r <= total_r + 32'(count_r);
         count_r <= start_val;
         phase_r <= spo_pkg::SPO_PH_RUN;
      end
      else if (ar_now)
      begin
         total_r <= total_r + 32'(cnt_n);
         count_r <= start_val;
      end
      else if (run_ev)
      begin
         count_r <= cnt_n;
         if (term && mode == spo_pkg::SPO_MAN_STOP)
            phase_r <= spo_pkg::SPO_PH_STOP;
         else if (term && mode == spo_pkg::SPO_AUTO_WAIT && auto_ok)
            phase_r <= spo_pkg::SPO_PH_WAIT;
      end
   end

   // display hold after reset at terminal
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         hold_r <= 1'b0;
      else if (mr_ev || t2_exp)
         hold_r <= 1'b0;
      else if (ar_now && mode == spo_pkg::SPO_AUTO_HOLD)
         hold_r <= 1'b1;
   end

   // outputs and pulse timers
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_out1 <= 1'b0;
         o_out2 <= 1'b0;
         t1_r   <= '0;
         t2_r   <= '0;
      end
      else if (mr_ev)
      begin
         o_out1 <= 1'b0;
         o_out2 <= 1'b0;
         t1_r   <= '0;
         t2_r   <= '0;
      end
      else if (mode == spo_pkg::SPO_COMPARE)
      begin
         o_out1 <= cmp1;
         o_out2 <= cmp2;
         t1_r   <= '0;
         t2_r   <= '0;
      end
      else
      begin
         if (tick && t1_r != '0)
            t1_r <= t1_r - PT_W'(1);
         if (tick && t2_r != '0)
            t2_r <= t2_r - PT_W'(1);
         if (run_ev && hit1)
         begin
            o_out1 <= 1'b1;
            t1_r   <= pt1_r;
         end
         // output 2 end drops output 1
         else if (t1_exp || t2_exp)
            o_out1 <= 1'b0;
         if (run_ev && term)
         begin
            o_out2 <= 1'b1;
            t2_r   <= (mode == spo_pkg::SPO_MAN_STOP) ? '0 : pt2_r;
         end
         else if (t2_exp)
            o_out2 <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         o_disp <= 32'h0;
      else if (hold_r)
         o_disp <= 32'(term_val);
      else
         o_disp <= 32'(count_r);
   end

   // register writes
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         ctrl_r <= `SPO_RST_CTRL;
         first_setpoint_r <= CNT_W'(`SPO_RST_SET);
         second_setpoint_r <= CNT_W'(`SPO_RST_SET);
         pt1_r  <= PT_W'(`SPO_RST_PT);
         pt2_r  <= PT_W'(`SPO_RST_PT);
         mask_r <= `SPO_RST_MASK;
      end
      else if (i_wr)
      begin
         case (i_addr)
            `SPO_OFS_CTRL: ctrl_r <= i_wdata;
            `SPO_OFS_FIRST_SETPOINT: first_setpoint_r <= i_wdata[CNT_W-1:0];
            `SPO_OFS_SECOND_SETPOINT: second_setpoint_r <= i_wdata[CNT_W-1:0];
            `SPO_OFS_PT1:  pt1_r  <= i_wdata[PT_W-1:0];
            `SPO_OFS_PT2:  pt2_r  <= i_wdata[PT_W-1:0];
            `SPO_OFS_MASK: mask_r <= i_wdata[`SPO_ST_W-1:0];
            default:       ;
         endcase
      end
   end

   // sticky events, set wins over write-one-clear
   assign first_setpoint_ev = ~o_out1 & ((run_ev & hit1 & (mode != spo_pkg::SPO_COMPARE))
                  | ((mode == spo_pkg::SPO_COMPARE) & cmp1));
   assign second_setpoint_ev = ~o_out2 & ((run_ev & term & (mode != spo_pkg::SPO_COMPARE))
                  | ((mode == spo_pkg::SPO_COMPARE) & cmp2));
   assign ev_vec  = {mr_ev, ar_now | late_rst, second_setpoint_ev & ~mr_ev, first_setpoint_ev & ~mr_ev};

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         stat_r <= '0;
      else if (i_wr && i_addr == `SPO_OFS_STAT)
         stat_r <= (stat_r & ~i_wdata[`SPO_ST_W-1:0]) | ev_vec;
      else
         stat_r <= stat_r | ev_vec;
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         o_irq <= 1'b0;
      else
         o_irq <= |(stat_r & mask_r);
   end

   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         o_rdata <= 32'h0;
      else if (!i_rd)
         o_rdata <= 32'h0;
      else
      begin
         case (i_addr)
            `SPO_OFS_CTRL:  o_rdata <= ctrl_r;
            `SPO_OFS_FIRST_SETPOINT:  o_rdata <= 32'(first_setpoint_r);
            `SPO_OFS_SECOND_SETPOINT:  o_rdata <= 32'(second_setpoint_r);
            `SPO_OFS_PT1:   o_rdata <= 32'(pt1_r);
            `SPO_OFS_PT2:   o_rdata <= 32'(pt2_r);
            `SPO_OFS_COUNT: o_rdata <= 32'(count_r);
            `SPO_OFS_TOTAL: o_rdata <= total_r;
            `SPO_OFS_DISP:  o_rdata <= o_disp;
            `SPO_OFS_STAT:  o_rdata <= 32'(stat_r);
            `SPO_OFS_MASK:  o_rdata <= 32'(mask_r);
            `SPO_OFS_OUTS:  o_rdata <= {28'h0, hold_r, phase_r != spo_pkg::SPO_PH_RUN,
                                        o_out2, o_out1};
            default:        o_rdata <= 32'h0;
         endcase
      end
   end

   // checks
   property p_out1_set;
      @(posedge i_clk) disable iff (!i_arst_n)
      (run_ev && hit1 && mode != spo_pkg::SPO_COMPARE) |=> o_out1;
   endproperty
   a_out1_set: assert property (p_out1_set) else $error("output 1 not set");
   property p_stop_hold;
      @(posedge i_clk) disable iff (!i_arst_n)
      (phase_r != spo_pkg::SPO_PH_RUN && !mr_ev && !late_rst) |=> (count_r == $past(count_r));
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("count moved while halted");
   property p_o2_drop;
      @(posedge i_clk) disable iff (!i_arst_n)
      (t2_exp && !mr_ev && mode != spo_pkg::SPO_COMPARE && !(run_ev && (term || hit1)))
      |=> (!o_out2 && !o_out1);
   endproperty
   a_o2_drop: assert property (p_o2_drop) else $error("outputs not dropped");
   property p_auto_up;
      @(posedge i_clk) disable iff (!i_arst_n)
      (ar_now && !down) |=> (count_r == '0) && o_out2;
   endproperty
   a_auto_up: assert property (p_auto_up) else $error("up auto reset wrong");
   property p_auto_dn;
      @(posedge i_clk) disable iff (!i_arst_n)
      (ar_now && down) |=> (count_r == $signed($past(second_setpoint_r)));
   endproperty
   a_auto_dn: assert property (p_auto_dn) else $error("down reload wrong");
   property p_total;
      @(posedge i_clk) disable iff (!i_arst_n)
      (ar_now && !late_rst && !mr_ev) |=> (total_r == $past(total_r) + 32'($past(cnt_n)));
   endproperty
   a_total: assert property (p_total) else $error("total not updated");
   property p_no_auto;
      @(posedge i_clk) disable iff (!i_arst_n)
      (run_ev && is_auto && pt2_r == '0) |=> (count_r == $past(cnt_n));
   endproperty
   a_no_auto: assert property (p_no_auto) else $error("auto reset with zero time");
   property p_cmp_up;
      @(posedge i_clk) disable iff (!i_arst_n)
      (mode == spo_pkg::SPO_COMPARE && !down && !mr_ev)
      |=> (o_out1 == $past(cmp1)) && (o_out2 == $past(cmp2));
   endproperty
   a_cmp_up: assert property (p_cmp_up) else $error("compare outputs wrong");
   property p_cmp_dn;
      @(posedge i_clk) disable iff (!i_arst_n)
      (mode == spo_pkg::SPO_COMPARE && down && !mr_ev && count_r > $signed(first_setpoint_r))
      |=> !o_out1;
   endproperty
   a_cmp_dn: assert property (p_cmp_dn) else $error("compare down wrong");
   property p_man_total;
      @(posedge i_clk) disable iff (!i_arst_n)
      mr_ev |=> (total_r == $past(total_r) + 32'($past(count_r))) && !o_out2;
   endproperty
   a_man_total: assert property (p_man_total) else $error("manual total wrong");
   property p_tick;
      @(posedge i_clk) disable iff (!i_arst_n)
      tick |=> !tick [*2];
   endproperty
   a_tick: assert property (p_tick) else $error("tick too frequent");

endmodule

// ==== verification/spo_field.sv ====
`timescale 1ns/10ps

module spo_field (
   // clock
   input  wire logic i_clk,
   // field pins
   output logic      o_cnt_pulse,
   output logic      o_man_rst
);
   // cycles each level is held; raise it to play a slow sensor
   int hold_cyc;

   initial
   begin
      hold_cyc    = 3;
      o_cnt_pulse = 1'b0;
      o_man_rst   = 1'b0;
   end

   // levels held at least two cycles so the pin synchroniser catches them
   task automatic pulses(input int n);
      repeat (n)
      begin
         @(posedge i_clk);
         o_cnt_pulse <= 1'b1;
         repeat (hold_cyc) @(posedge i_clk);
         o_cnt_pulse <= 1'b0;
         repeat (hold_cyc) @(posedge i_clk);
      end
   endtask

   task automatic man_reset;
      @(posedge i_clk);
      o_man_rst <= 1'b1;
      repeat (hold_cyc) @(posedge i_clk);
      o_man_rst <= 1'b0;
      repeat (hold_cyc + 2) @(posedge i_clk);
   endtask
endmodule

// ==== verification/spo_top_bench.sv ====
`timescale 1ns/10ps
`include "spo_cfg.svh"

module spo_top_bench;
   localparam int          TB_CYC = 4;
   localparam logic [31:0] ALL    = 32'hffff_ffff;

   logic        clk;
   logic        arst_n;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        wr_s;
   logic        rd_s;
   logic [31:0] rdata;
   logic        cnt_pulse;
   logic        man_rst;
   logic        out1;
   logic        out2;
   logic [31:0] disp;
   logic        irq;
   logic        rd_q = 1'b0;
   logic [63:0] exp_q[$];
   logic [63:0] ent;
   int          bad_count;
   int          n_tests;
   integer      seed;
   int          tot;
   int          r;
   int          i;

   spo_top #(.TB_CYC(TB_CYC)) dut (
      .i_clk       (clk),
      .i_arst_n    (arst_n),
      .i_addr      (addr),
      .i_wdata     (wdata),
      .i_wr        (wr_s),
      .i_rd        (rd_s),
      .o_rdata     (rdata),
      .i_cnt_pulse (cnt_pulse),
      .i_man_rst   (man_rst),
      .o_out1      (out1),
      .o_out2      (out2),
      .o_disp      (disp),
      .o_irq       (irq)
   );

   spo_field field (
      .i_clk       (clk),
      .o_cnt_pulse (cnt_pulse),
      .o_man_rst   (man_rst)
   );

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic finish_test;
      $display("checks %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
      begin
         $display("NO MISMATCHES");
      end
      else
      begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic cmp_rd(input logic [31:0] got, input logic [31:0] e, input logic [31:0] m);
      n_tests++;
      if ((got & m) !== (e & m))
      begin
         bad_count++;
         $display("[FAIL] %0t read got %h expected %h", $time, got, e);
      end
   endtask

   // pins sampled at the falling edge, well clear of register updates
   task automatic chk_pin(ref logic got, input logic e);
      @(negedge clk);
      n_tests++;
      if (got !== e)
      begin
         bad_count++;
         $display("[FAIL] %0t pin got %b expected %b", $time, got, e);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr_s  <= 1'b1;
      @(posedge clk);
      wr_s  <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      exp_q.push_back({e, m});
      @(posedge clk);
      rd_s <= 1'b0;
   endtask

   // read data is valid only in the cycle after the strobe
   always @(posedge clk)
   begin
      if (rd_q)
      begin
         if (exp_q.size() == 0)
         begin
            bad_count++;
            $display("[FAIL] %0t read data with nothing expected", $time);
         end
         else
         begin
            ent = exp_q.pop_front();
            cmp_rd(rdata, ent[63:32], ent[31:0]);
         end
      end
      rd_q <= rd_s;
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      $display("[FAIL] %0t run did not finish", $time);
      finish_test();
   end

   initial
   begin
      arst_n    = 1'b0;
      addr      = 8'h00;
      wdata     = 32'h0;
      wr_s      = 1'b0;
      rd_s      = 1'b0;
      bad_count = 0;
      n_tests   = 0;
      seed      = 32'h6761da05;
      r         = 3 + ($unsigned($random(seed)) % 4);
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      // every place reads zero after reset, the unmapped one too
      for (i = 0; i < 12; i++)
      begin
         rd(8'(i * 4), 32'h0, ALL);
      end
      wr(`SPO_OFS_COUNT, 32'h55);
      rd(`SPO_OFS_COUNT, 32'h0, ALL);
      // manual-stop downcount
      wr(`SPO_OFS_FIRST_SETPOINT, 32'h3);
      wr(`SPO_OFS_SECOND_SETPOINT, 32'h5);
      rd(`SPO_OFS_SECOND_SETPOINT, 32'h5, ALL);
      wr(`SPO_OFS_CTRL, 32'h100);
      field.man_reset();
      field.pulses(2);
      chk_pin(out1, 1'b1);
      chk_pin(out2, 1'b0);
      field.pulses(5);
      chk_pin(out2, 1'b1);
      chk_pin(out1, 1'b1);
      rd(`SPO_OFS_COUNT, 32'h0, ALL);
      // basic automatic reset, upcount, slow sensor
      wr(`SPO_OFS_CTRL, 32'h2);
      wr(`SPO_OFS_FIRST_SETPOINT, 32'h1);
      wr(`SPO_OFS_SECOND_SETPOINT, 32'(r));
      wr(`SPO_OFS_PT2, 32'h8);
      wr(`SPO_OFS_MASK, 32'h2);
      // stale output-2 event from the halted run would hide the interrupt check
      wr(`SPO_OFS_STAT, 32'hf);
      repeat (2) @(posedge clk);
      chk_pin(irq, 1'b0);
      field.hold_cyc = 5;
      field.man_reset();
      field.pulses(r - 1);
      field.man_reset();
      tot = r - 1;
      field.pulses(r);
      tot += r;
      chk_pin(out2, 1'b1);
      chk_pin(out1, 1'b1);
      chk_pin(irq, 1'b1);
      rd(`SPO_OFS_COUNT, 32'h0, ALL);
      rd(`SPO_OFS_TOTAL, 32'(tot), ALL);
      rd(`SPO_OFS_STAT, 32'h6, 32'h6);
      repeat (50) @(posedge clk);
      chk_pin(out2, 1'b0);
      chk_pin(out1, 1'b0);
      wr(`SPO_OFS_STAT, 32'hf);
      repeat (2) @(posedge clk);
      chk_pin(irq, 1'b0);
      wr(`SPO_OFS_MASK, 32'h0);
      // zero pulse time: no automatic reset
      field.hold_cyc = 3;
      wr(`SPO_OFS_PT2, 32'h0);
      field.pulses(r + 1);
      chk_pin(out2, 1'b1);
      chk_pin(irq, 1'b0);
      rd(`SPO_OFS_COUNT, 32'(r + 1), ALL);
      // basic automatic reset, downcount
      wr(`SPO_OFS_CTRL, 32'h102);
      wr(`SPO_OFS_PT2, 32'h8);
      field.man_reset();
      tot += r + 1;
      field.pulses(r);
      chk_pin(out2, 1'b1);
      rd(`SPO_OFS_COUNT, 32'(r), ALL);
      repeat (50) @(posedge clk);
      // stop-and-wait
      wr(`SPO_OFS_CTRL, 32'h3);
      field.man_reset();
      tot += r;
      field.pulses(r + 2);
      chk_pin(out2, 1'b1);
      rd(`SPO_OFS_COUNT, 32'(r), ALL);
      rd(`SPO_OFS_OUTS, 32'h6, 32'h6);
      repeat (50) @(posedge clk);
      tot += r;
      chk_pin(out2, 1'b0);
      rd(`SPO_OFS_COUNT, 32'h0, ALL);
      rd(`SPO_OFS_TOTAL, 32'(tot), ALL);
      // display hold, upcount
      wr(`SPO_OFS_CTRL, 32'h4);
      field.pulses(r);
      tot += r;
      @(negedge clk);
      cmp_rd(disp, 32'(r), ALL);
      rd(`SPO_OFS_COUNT, 32'h0, ALL);
      repeat (50) @(posedge clk);
      @(negedge clk);
      cmp_rd(disp, 32'h0, ALL);
      // overrun, upcount then downcount
      wr(`SPO_OFS_CTRL, 32'h5);
      field.pulses(r + 1);
      chk_pin(out2, 1'b1);
      rd(`SPO_OFS_COUNT, 32'(r + 1), ALL);
      repeat (50) @(posedge clk);
      tot += r + 1;
      chk_pin(out2, 1'b0);
      rd(`SPO_OFS_COUNT, 32'h0, ALL);
      wr(`SPO_OFS_CTRL, 32'h105);
      field.man_reset();
      field.pulses(r + 1);
      chk_pin(out2, 1'b1);
      rd(`SPO_OFS_COUNT, 32'hffff_ffff, ALL);
      repeat (50) @(posedge clk);
      tot -= 1;
      rd(`SPO_OFS_COUNT, 32'(r), ALL);
      // continuing manual mode, upcount
      wr(`SPO_OFS_CTRL, 32'h1);
      field.man_reset();
      tot += r;
      field.pulses(r + 1);
      chk_pin(out2, 1'b1);
      rd(`SPO_OFS_COUNT, 32'(r + 1), ALL);
      repeat (50) @(posedge clk);
      chk_pin(out2, 1'b0);
      chk_pin(out1, 1'b0);
      rd(`SPO_OFS_COUNT, 32'(r + 1), ALL);
      tot += r + 1;
      // comparator, up then down
      wr(`SPO_OFS_CTRL, 32'h6);
      wr(`SPO_OFS_FIRST_SETPOINT, 32'h2);
      wr(`SPO_OFS_SECOND_SETPOINT, 32'h4);
      field.man_reset();
      for (i = 1; i <= 5; i++)
      begin
         field.pulses(1);
         chk_pin(out1, i >= 2);
         chk_pin(out2, i >= 4);
      end
      wr(`SPO_OFS_CTRL, 32'h106);
      field.man_reset();
      tot += 5;
      rd(`SPO_OFS_TOTAL, 32'(tot), ALL);
      for (i = 3; i >= 0; i--)
      begin
         field.pulses(1);
         chk_pin(out1, i <= 2);
      end
      repeat (4) @(posedge clk);
      finish_test();
   end
endmodule
